// ### logic/utd_pkg.sv
// constants and enumerations for the usb termination decoder
package utd_pkg;
  localparam logic [1:0] UTD_XS_HS = 2'h0;
  localparam logic [1:0] UTD_XS_FS = 2'h1;
  localparam logic [1:0] UTD_XS_LS = 2'h2;
  localparam logic [1:0] UTD_MD_NORMAL = 2'h0;
  localparam logic [1:0] UTD_MD_OFF = 2'h1;
  localparam logic [1:0] UTD_MD_NOSTUFF = 2'h2;
  localparam int UTD_TRIM_W = 2;
  localparam int UTD_EN_W = 5;
  // enable vector order: pu_plus, pu_minus, pd_plus, pd_minus, hs_term
  localparam logic [4:0] UTD_EN_NONE = 5'h00;
  localparam logic [4:0] UTD_EN_PU_P = 5'h10;
  localparam logic [4:0] UTD_EN_PU_M = 5'h08;
  localparam logic [4:0] UTD_EN_PD_P = 5'h04;
  localparam logic [4:0] UTD_EN_PD_M = 5'h02;
  localparam logic [4:0] UTD_EN_HST = 5'h01;
  localparam logic [4:0] UTD_EN_PD_BOTH = 5'h06;
  localparam logic [1:0] UTD_RST_XS = 2'h1;
  localparam logic [1:0] UTD_RST_MD = 2'h0;
  localparam logic UTD_RST_TS = 1'b0;
  localparam logic UTD_RST_REQ = 1'b1;
  // 11b is a second full-speed code, valid only in the host fs/ls row, where termination_choice is set
  localparam logic [1:0] UTD_XS_ALT = 2'h3;
  localparam logic [1:0] UTD_MD_RSVD = 2'h3;
  localparam logic [1:0] UTD_REQ_BOTH = 2'h3;
  localparam logic UTD_LINE_IDLE = 1'b1;
  localparam logic [2:0] UTD_STUFF_RUN = 3'h6;
  typedef enum logic [1:0] {UTD_RX_IDLE, UTD_RX_HS, UTD_RX_FS} utd_rx_e;
endpackage : utd_pkg

// ### logic/utd_decode.sv
// combinational table decode from register fields to resistor enables
`timescale 1ns/100ps
module utd_decode
  import utd_pkg::*;
(
  // fields
  input wire logic [1:0] transceiver_speed_select,
  input wire logic termination_choice,
  input wire logic [1:0] line_drive_mode,
  input wire logic plus_line_low_request,
  input wire logic minus_line_low_request,
  // result
  output logic [4:0] enables
);
  logic [1:0] req;
  assign req = {plus_line_low_request, minus_line_low_request};
  always_comb begin
    enables = UTD_EN_NONE;
    if (line_drive_mode == UTD_MD_OFF) begin
      enables = UTD_EN_NONE;
    end else if (req == UTD_REQ_BOTH) begin
      if (transceiver_speed_select == UTD_XS_HS && !termination_choice &&
          line_drive_mode != UTD_MD_RSVD) begin
        enables = UTD_EN_PD_BOTH | UTD_EN_HST;
      end else if (transceiver_speed_select == UTD_XS_FS && !termination_choice &&
                   line_drive_mode == UTD_MD_NORMAL) begin
        enables = UTD_EN_PD_BOTH;
      end else if (transceiver_speed_select != UTD_XS_HS && termination_choice &&
                   line_drive_mode != UTD_MD_RSVD &&
                   !(transceiver_speed_select == UTD_XS_ALT &&
                     line_drive_mode == UTD_MD_NOSTUFF)) begin
        // 11b with resume signalling matches no row and falls to all off
        enables = UTD_EN_PD_BOTH;
      end
    end else if (!req[1]) begin
      // peripheral rows; a minus request adds the minus pull-down, except in the low-speed row, where it leaves all off
      if (transceiver_speed_select == UTD_XS_HS && termination_choice &&
          line_drive_mode == UTD_MD_NOSTUFF) begin
        enables = UTD_EN_PU_P;
      end else if (transceiver_speed_select == UTD_XS_HS && !termination_choice &&
                   line_drive_mode != UTD_MD_RSVD) begin
        enables = UTD_EN_HST;
      end else if (transceiver_speed_select == UTD_XS_FS && termination_choice &&
                   line_drive_mode != UTD_MD_RSVD) begin
        enables = UTD_EN_PU_P;
      end else if (transceiver_speed_select == UTD_XS_LS && termination_choice &&
                   line_drive_mode != UTD_MD_RSVD && !req[0]) begin
        enables = UTD_EN_PU_M;
      end
      if (req[0] && enables != UTD_EN_NONE) begin
        enables = enables | UTD_EN_PD_M;
      end
    end
  end
endmodule : utd_decode

// ### logic/utd_top.sv
// usb termination decoder with receive select and transmit path roles
`timescale 1ns/100ps
module utd_top
  import utd_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // control fields, written by the link
  input wire logic field_write,
  input wire logic [1:0] transceiver_speed_select,
  input wire logic termination_choice,
  input wire logic [1:0] line_drive_mode,
  input wire logic plus_line_low_request,
  input wire logic minus_line_low_request,
  input wire logic [1:0] amplitude_trim,
  input wire logic synchronous_mode,
  // receivers
  input wire logic hs_rx_data,
  input wire logic hs_squelch,
  input wire logic fs_rx_data,
  input wire logic plus_line_se,
  input wire logic minus_line_se,
  // transmit logic
  input wire logic tx_bit_valid,
  input wire logic tx_bit,
  // resistor enables
  output logic plus_line_pullup_on,
  output logic minus_line_pullup_on,
  output logic plus_line_pulldown_on,
  output logic minus_line_pulldown_on,
  output logic highspeed_termination_on,
  // receive side
  output logic rx_stream,
  output logic rx_stream_valid,
  output logic [1:0] fs_line_state,
  // transmit side
  output logic tx_line_bit,
  output logic tx_line_active,
  output logic tx_hs_select,
  output logic [1:0] hs_amplitude_trim
);
  // ****************************************
  // field registers
  // ****************************************
  logic [1:0] xs, next_xs;
  logic ts, next_ts;
  logic [1:0] md, next_md;
  logic pdp, next_pdp;
  logic pdm, next_pdm;
  logic [1:0] trim, next_trim;
  // all fields land on one edge, so no half-written row is ever decoded
  always_comb begin
    next_xs = xs;
    next_ts = ts;
    next_md = md;
    next_pdp = pdp;
    next_pdm = pdm;
    next_trim = trim;
    if (field_write) begin
      next_xs = transceiver_speed_select;
      next_ts = termination_choice;
      next_md = line_drive_mode;
      next_pdp = plus_line_low_request;
      next_pdm = minus_line_low_request;
      next_trim = amplitude_trim;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      // power-up values select the two pull-downs
      xs <= UTD_RST_XS;
      ts <= UTD_RST_TS;
      md <= UTD_RST_MD;
      pdp <= UTD_RST_REQ;
      pdm <= UTD_RST_REQ;
      trim <= '0;
    end else begin
      xs <= next_xs;
      ts <= next_ts;
      md <= next_md;
      pdp <= next_pdp;
      pdm <= next_pdm;
      trim <= next_trim;
    end
  end
  // ****************************************
  // resistor decode
  // ****************************************
  // decode stays combinational; only its result is registered
  logic [4:0] dec_en;
  logic [4:0] res_en, next_res_en;
  utd_decode u_decode (
    .transceiver_speed_select(xs),
    .termination_choice(ts),
    .line_drive_mode(md),
    .plus_line_low_request(pdp),
    .minus_line_low_request(pdm),
    .enables(dec_en)
  );
  // outside synchronous mode the enables hold their last value
  always_comb begin
    next_res_en = res_en;
    if (synchronous_mode) begin
      next_res_en = dec_en;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      res_en <= UTD_EN_PD_BOTH;
    end else begin
      res_en <= next_res_en;
    end
  end
  // one flop lag after the field register; enables settle two edges after write
  assign plus_line_pullup_on = res_en[4];
  assign minus_line_pullup_on = res_en[3];
  assign plus_line_pulldown_on = res_en[2];
  assign minus_line_pulldown_on = res_en[1];
  assign highspeed_termination_on = res_en[0];
  // ****************************************
  // receive path
  // ****************************************
  utd_rx_e rx_sel;
  logic next_rx_stream, next_rx_valid;
  logic [1:0] next_ls;
  logic hs_mode;
  assign hs_mode = (xs == UTD_XS_HS);
  // squelched hs data still passes; it is only marked not valid
  // line state bypasses the speed mux so bus states stay visible
  always_comb begin
    rx_sel = hs_mode ? UTD_RX_HS : UTD_RX_FS;
    if (md == UTD_MD_OFF) begin
      rx_sel = UTD_RX_IDLE;
    end
    next_rx_stream = 1'b0;
    next_rx_valid = 1'b0;
    case (rx_sel)
      UTD_RX_HS: begin
        next_rx_stream = hs_rx_data;
        next_rx_valid = !hs_squelch;
      end
      UTD_RX_FS: begin
        next_rx_stream = fs_rx_data;
        next_rx_valid = 1'b1;
      end
      default: begin
        next_rx_stream = 1'b0;
        next_rx_valid = 1'b0;
      end
    endcase
    next_ls = {minus_line_se, plus_line_se};
  end
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      rx_stream <= 1'b0;
      rx_stream_valid <= 1'b0;
      fs_line_state <= '0;
    end else begin
      rx_stream <= next_rx_stream;
      rx_stream_valid <= next_rx_valid;
      fs_line_state <= next_ls;
    end
  end
  // ****************************************
  // transmit path: nrzi encode and bit stuff
  // ****************************************
  // stuffing is done per accepted bit; the source must pace itself
  logic nrzi, next_nrzi;
  logic [2:0] ones, next_ones;
  logic next_act;
  logic stuff;
  assign stuff = (ones == UTD_STUFF_RUN) && (md != UTD_MD_NOSTUFF);
  always_comb begin
    next_nrzi = nrzi;
    next_ones = ones;
    next_act = tx_bit_valid && (md != UTD_MD_OFF);
    if (next_act) begin
      if (stuff || !tx_bit) begin
        next_nrzi = !nrzi;
        next_ones = '0;
      end else if (ones != UTD_STUFF_RUN) begin
        // saturate: a run carried out of no-stuff mode is still broken
        next_ones = ones + 3'h1;
      end
    end else begin
      next_ones = '0;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      nrzi <= UTD_LINE_IDLE;
      ones <= '0;
      tx_line_active <= 1'b0;
      tx_line_bit <= UTD_LINE_IDLE;
    end else begin
      nrzi <= next_nrzi;
      ones <= next_ones;
      tx_line_active <= next_act;
      tx_line_bit <= next_nrzi;
    end
  end
  // ****************************************
  // transmit speed and amplitude
  // ****************************************
  // trim only scales the hs driver; it never touches the resistors
  logic next_hs_sel;
  logic [1:0] next_hs_trim;
  always_comb begin
    next_hs_sel = hs_mode;
    next_hs_trim = trim;
  end
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      tx_hs_select <= 1'b0;
      hs_amplitude_trim <= '0;
    end else begin
      tx_hs_select <= next_hs_sel;
      hs_amplitude_trim <= next_hs_trim;
    end
  end
endmodule : utd_top

// ### verif/utd_top_monitor.sv
// assertion checker for the termination decoder enables
`timescale 1ns/100ps
module utd_top_monitor
  import utd_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // fields
  input wire logic field_write,
  input wire logic [1:0] transceiver_speed_select,
  input wire logic termination_choice,
  input wire logic [1:0] line_drive_mode,
  input wire logic plus_line_low_request,
  input wire logic minus_line_low_request,
  input wire logic synchronous_mode,
  // enables
  input wire logic plus_line_pullup_on,
  input wire logic minus_line_pullup_on,
  input wire logic plus_line_pulldown_on,
  input wire logic minus_line_pulldown_on,
  input wire logic highspeed_termination_on
);
  // ****************************************
  // helpers and properties
  // ****************************************
  wire logic [4:0] en = {plus_line_pullup_on, minus_line_pullup_on, plus_line_pulldown_on,
    minus_line_pulldown_on, highspeed_termination_on};
  wire logic [6:0] f = {transceiver_speed_select, termination_choice, line_drive_mode,
    plus_line_low_request, minus_line_low_request};
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // two edges: field register, then enable register
  property p_row(cond, exp);
    field_write && cond ##1 synchronous_mode |=> en == exp;
  endproperty
  a_powerup_pulldowns: assert property (p_row(f == 7'h23, UTD_EN_PD_BOTH))
    else $error("power-up row wrong");
  a_host_hs_term: assert property (p_row((f & 7'h77) == 7'h03, 5'h07))
    else $error("host hs row wrong");
  a_host_fs_ls: assert property (p_row(f[4] && !f[2] && f[1:0] == 2'h3 &&
    f[6:5] != 2'h0 && f[6:3] != 4'hF, UTD_EN_PD_BOTH))
    else $error("host fs or ls row wrong");
  a_periph_chirp: assert property (p_row(f == 7'h18, UTD_EN_PU_P))
    else $error("peripheral chirp row wrong");
  a_periph_hs: assert property (p_row(f == 7'h00, UTD_EN_HST))
    else $error("peripheral hs row wrong");
  a_otg_minus_pd: assert property (p_row(f == 7'h19, 5'h12))
    else $error("otg chirp row wrong");
  a_tristate_all_off: assert property (p_row(f[3:2] == 2'h1, UTD_EN_NONE))
    else $error("tri-state mode left an enable on");
  a_undefined_off: assert property (p_row(f[3:2] == 2'h3, UTD_EN_NONE))
    else $error("undefined row left an enable on");
  a_async_freeze: assert property (!synchronous_mode |=> $stable(en))
    else $error("enables moved outside synchronous mode");
  c_chirp: cover property (field_write && f == 7'h18);
  c_tristate: cover property (field_write && f[3:2] == 2'h1);
  c_frozen: cover property (!synchronous_mode && field_write);
endmodule : utd_top_monitor

bind utd_top utd_top_monitor mon (.ref_clk(ref_clk), .rstn(rstn), .field_write(field_write),
  .transceiver_speed_select(transceiver_speed_select), .termination_choice(termination_choice),
  .line_drive_mode(line_drive_mode), .plus_line_low_request(plus_line_low_request),
  .minus_line_low_request(minus_line_low_request), .synchronous_mode(synchronous_mode),
  .plus_line_pullup_on(plus_line_pullup_on), .minus_line_pullup_on(minus_line_pullup_on),
  .plus_line_pulldown_on(plus_line_pulldown_on),
  .minus_line_pulldown_on(minus_line_pulldown_on),
  .highspeed_termination_on(highspeed_termination_on));

// ### verif/utd_line_model.sv
// far-side line model feeding the receivers
`timescale 1ns/100ps
module utd_line_model (
  // commands from the bench
  input wire logic squelch_req,
  input wire logic [2:0] pattern,
  // receiver inputs
  output logic hs_rx_data,
  output logic hs_squelch,
  output logic fs_rx_data,
  output logic plus_line_se,
  output logic minus_line_se
);
  assign hs_squelch = squelch_req;
  // squelched line shows the inverted pattern bit, not the bit itself
  assign hs_rx_data = squelch_req ? ~pattern[0] : pattern[0];
  assign {minus_line_se, plus_line_se, fs_rx_data} = pattern;
endmodule : utd_line_model

// ### verif/test_usb_termination_decoder.sv
// self-checking bench for the termination decoder
`timescale 1ns/100ps
module test_usb_termination_decoder
  import utd_pkg::*;
;
  logic ref_clk, rstn, fw, tc, pl, ml, sync, sq, tv, tb;
  logic hrd, hsq, frd, pse, mse, rs, rv, tlb, tla, ths;
  logic [1:0] xs, md, ls, trim_in, trim_out;
  logic [2:0] pat;
  logic [4:0] en;
  int bad_count = 0;
  int total_checks = 0;
  // fields {xs, tc, md, pl, ml} then expected enables
  logic [11:0] rows [14] = '{{7'h23, 5'h06}, {7'h0B, 5'h07}, {7'h03, 5'h07}, {7'h73, 5'h06},
    {7'h3B, 5'h06}, {7'h5B, 5'h06}, {7'h18, 5'h10}, {7'h00, 5'h01}, {7'h50, 5'h08},
    {7'h30, 5'h10}, {7'h57, 5'h00}, {7'h7B, 5'h00}, {7'h0F, 5'h00}, {7'h19, 5'h12}};
  utd_top dut (.ref_clk(ref_clk), .rstn(rstn), .field_write(fw), .transceiver_speed_select(xs),
    .termination_choice(tc), .line_drive_mode(md), .plus_line_low_request(pl),
    .minus_line_low_request(ml), .amplitude_trim(trim_in), .synchronous_mode(sync),
    .hs_rx_data(hrd), .hs_squelch(hsq), .fs_rx_data(frd), .plus_line_se(pse),
    .minus_line_se(mse), .tx_bit_valid(tv), .tx_bit(tb), .plus_line_pullup_on(en[4]),
    .minus_line_pullup_on(en[3]), .plus_line_pulldown_on(en[2]),
    .minus_line_pulldown_on(en[1]), .highspeed_termination_on(en[0]), .rx_stream(rs),
    .rx_stream_valid(rv), .fs_line_state(ls), .tx_line_bit(tlb), .tx_line_active(tla),
    .tx_hs_select(ths), .hs_amplitude_trim(trim_out));
  utd_line_model line (.squelch_req(sq), .pattern(pat), .hs_rx_data(hrd), .hs_squelch(hsq),
    .fs_rx_data(frd), .plus_line_se(pse), .minus_line_se(mse));
  // ****************************************
  // tasks
  // ****************************************
  task automatic check(input string nm, input logic [4:0] seen, input logic [4:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic put(input logic [6:0] v);
    {xs, tc, md, pl, ml} = v;
    fw = 1'b1;
    @(negedge ref_clk);
    fw = 1'b0;
    repeat (2) @(negedge ref_clk);
  endtask : put
  task automatic results;
    if (bad_count == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results
  // ****************************************
  // clock, watchdog and sequence
  // ****************************************
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  initial begin
    #20000;
    bad_count++;
    results();
  end
  initial begin
    {rstn, fw, xs, tc, md, pl, ml, sq, tv, tb, pat, trim_in} = '0;
    sync = 1'b1;
    repeat (4) @(negedge ref_clk);
    rstn = 1'b1;
    check("reset enables", en, UTD_EN_PD_BOTH);
    foreach (rows[i]) begin
      put(rows[i][11:5]);
      check("table enables", en, rows[i][4:0]);
    end
    // fields land but enables must hold
    sync = 1'b0;
    put(7'h00);
    check("frozen enables", en, 5'h12);
    sync = 1'b1;
    @(negedge ref_clk);
    check("resumed enables", en, UTD_EN_HST);
    sq = 1'b1;
    pat = 3'h1;
    @(negedge ref_clk);
    check("squelched valid", {4'h0, rv}, 5'h00);
    sq = 1'b0;
    @(negedge ref_clk);
    check("hs stream", {3'h0, rs, rv}, 5'h03);
    trim_in = 2'h2;
    put(7'h30);
    pat = 3'h5;
    @(negedge ref_clk);
    check("fs stream and state", {2'h0, rs, ls}, 5'h06);
    check("amplitude trim", {3'h0, trim_out}, 5'h02);
    put(7'h03);
    tv = 1'b1;
    @(negedge ref_clk);
    check("tx first bit", {2'h0, tla, tlb, ths}, 5'h05);
    tb = 1'b1;
    // seventh one is replaced by the stuffed transition
    repeat (7) @(negedge ref_clk);
    check("tx stuffed bit", {2'h0, tla, tlb, ths}, 5'h07);
    tv = 1'b0;
    results();
  end
endmodule : test_usb_termination_decoder
